// >>> fsk_discriminator.sv
`timescale 1ns/10ps
package cid_pkg;

  // Clock and line timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIT_TIME_NS   = 833333; // One bit at 1200 baud
  localparam int HALF_MIN_NS   = 200000; // Half period at 2500 Hz
  localparam int HALF_MAX_NS   = 500000; // Half period at 1000 Hz
  localparam int HALF_SPLIT_NS = 294118; // Half period at 1700 Hz
  localparam int BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int HALF_MIN_CYC  = (HALF_MIN_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int HALF_MAX_CYC  = HALF_MAX_NS / CLK_PERIOD_NS;
  localparam int HALF_SPLIT_CYC = HALF_SPLIT_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 17;

  // Carrier needs this many in-band half periods
  localparam logic [3:0] CD_EDGES = 4'h8;

  // Register map
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam logic [3:0]  ADDR_BYTE   = 4'h8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Serial word
  localparam logic [3:0]  WORD_BITS   = 4'h8;
  localparam logic [2:0]  LAST_BIT    = 3'h7;

  // Synchroniser lanes
  localparam int SY_RING  = 0;
  localparam int SY_RC    = 1;
  localparam int SY_TONE  = 2;
  localparam int SY_GUARD = 3;
  localparam int SY_LINE  = 4;
  localparam int SY_SCLK  = 5;
  localparam int SYNC_N   = 6;

  typedef struct packed {
    logic power_down;
    logic demod_enable;
    logic mode;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 3'h0;

  typedef struct packed {
    logic int_active;
    logic tone_qualified;
    logic tone_early;
    logic call_arrival_n;
    logic byte_ready_n;
    logic carrier_present_n;
  } status_t;

  typedef enum logic [1:0] {FR_IDLE, FR_START, FR_DATA, FR_STOP} frame_t;

endpackage

module fsk_discriminator
  import cid_pkg::*;
#(
  parameter int HALF_MIN   = HALF_MIN_CYC,
  parameter int HALF_MAX   = HALF_MAX_CYC,
  parameter int HALF_SPLIT = HALF_SPLIT_CYC
)
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  // Control and synchronised line comparator
  input  wire logic enable_i,
  input  wire logic line_sq_i,
  // Recovered bit and carrier
  output logic      mark_o,
  output logic      carrier_o
);

  localparam logic [CNT_W-1:0] MIN_C   = CNT_W'(HALF_MIN);
  localparam logic [CNT_W-1:0] MAX_C   = CNT_W'(HALF_MAX);
  localparam logic [CNT_W-1:0] SPLIT_C = CNT_W'(HALF_SPLIT);
  localparam logic [CNT_W-1:0] STALL_C = CNT_W'(HALF_MAX + 1);

  logic             sq_d_ff;
  logic [CNT_W-1:0] span_ff;
  logic [3:0]       good_ff;
  logic             mark_ff;

  wire line_edge = line_sq_i ^ sq_d_ff;
  wire in_band   = (span_ff >= MIN_C) && (span_ff <= MAX_C);
  wire stalled   = (span_ff == STALL_C);
  wire good_full = (good_ff == CD_EDGES);

  // Half-period timer saturates: a dead line reads out of band
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i || !enable_i || line_edge)
      span_ff <= '0;
    else if (!stalled)
      span_ff <= span_ff + CNT_W'(1);
  end

  // Long half period is the low tone: mark in both standards
  always_ff @(posedge sys_clk_i)
  begin
    sq_d_ff <= line_sq_i;
    if (sys_rst_i || !enable_i)
      mark_ff <= 1'b1;
    else if (line_edge && in_band)
      mark_ff <= (span_ff > SPLIT_C);
  end

  // Carrier needs a run of in-band halves; noise bursts fail
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i || !enable_i || stalled)
      good_ff <= '0;
    else if (line_edge && !in_band)
      good_ff <= '0;
    else if (line_edge && !good_full)
      good_ff <= good_ff + 4'h1;
  end

  assign mark_o    = mark_ff;
  assign carrier_o = good_full;

endmodule

// >>> caller_id_serial_status_interface.sv
`timescale 1ns/10ps
module caller_id_serial_status_interface
  import cid_pkg::*;
#(
  parameter int BIT_CYC    = BIT_CYCLES,
  parameter int HALF_MIN   = HALF_MIN_CYC,
  parameter int HALF_MAX   = HALF_MAX_CYC,
  parameter int HALF_SPLIT = HALF_SPLIT_CYC
)
(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Ring and reversal trigger path
  input  wire logic              ring_sense_in_i,
  input  wire logic              hold_rc_node_i,
  output logic                   hold_rc_node_o,
  output logic                   hold_rc_node_oe_o,
  output logic                   call_arrival_out_o,
  // Dual tone alert path
  input  wire logic              tone_pair_det_i,
  input  wire logic              guard_time_node_i,
  output logic                   tone_early_out_o,
  output logic                   tone_qualified_out_o,
  // FSK line and serial host interface
  input  wire logic              fsk_line_sq_i,
  input  wire logic              shift_clock_in_i,
  output logic                   serial_data_o,
  output logic                   byte_ready_n_o,
  output logic                   carrier_present_n_o,
  // Open-drain interrupt
  output logic                   int_n_o,
  output logic                   int_n_oe_o
);

  localparam logic [CNT_W-1:0] BIT_C  = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_C = CNT_W'(BIT_CYC / 2 - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [SYNC_N-1:0] meta_ff;
  logic [SYNC_N-1:0] sync_ff;
  logic              sclk_d_ff;

  wire [SYNC_N-1:0] raw_in = {shift_clock_in_i, fsk_line_sq_i,
                              guard_time_node_i, tone_pair_det_i,
                              hold_rc_node_i, ring_sense_in_i};

  // Two flops on every pin lane before any use
  always_ff @(posedge sys_clk_i)
  begin
    meta_ff   <= sys_rst_i ? '0 : raw_in;
    sync_ff   <= sys_rst_i ? '0 : meta_ff;
    sclk_d_ff <= sys_rst_i ? 1'b0 : sync_ff[SY_SCLK];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and its decode

  ctrl_t ctrl_ff;

  wire active    = !ctrl_ff.power_down;
  wire demod_on  = active && ctrl_ff.demod_enable;
  wire byte_mode = ctrl_ff.mode;
  wire sclk_rise = sync_ff[SY_SCLK] && !sclk_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Ring and reversal trigger; kept alive through power-down

  logic call_n_ff;
  logic rc_oe_ff;
  logic od_low_ff;

  // Low while ringing or until the RC node recharges
  wire nxt_call_n = !(sync_ff[SY_RING] || !sync_ff[SY_RC]);

  always_ff @(posedge sys_clk_i)
  begin
    call_n_ff <= sys_rst_i ? 1'b1 : nxt_call_n;
    rc_oe_ff  <= sys_rst_i ? 1'b0 : sync_ff[SY_RING]; // Discharge cap
    od_low_ff <= 1'b0; // Open-drain pins only ever pull low
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dual tone steering outputs

  logic tone_early_ff;
  logic tone_qual_ff;

  // Qualified follows the guard node comparator; dropping it re-arms
  always_ff @(posedge sys_clk_i)
  begin
    tone_early_ff <= !sys_rst_i && active && sync_ff[SY_TONE];
    tone_qual_ff  <= !sys_rst_i && active
                     && sync_ff[SY_GUARD];
  end

  ////////////////////////////////////////////////////////////////////////////
  // FSK discriminator and carrier detect

  logic mark;
  logic carrier;
  logic carrier_n_ff;

  fsk_discriminator #(
    .HALF_MIN   (HALF_MIN),
    .HALF_MAX   (HALF_MAX),
    .HALF_SPLIT (HALF_SPLIT)
  ) u_disc (
    .sys_clk_i  (sys_clk_i),
    .sys_rst_i  (sys_rst_i),
    .enable_i   (demod_on),
    .line_sq_i  (sync_ff[SY_LINE]),
    .mark_o     (mark),
    .carrier_o  (carrier)
  );

  always_ff @(posedge sys_clk_i)
  begin
    carrier_n_ff <= sys_rst_i || !carrier;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character framer: start bit, eight data bits, stop bit

  frame_t           fr_ff;
  frame_t           nxt_fr;
  logic [CNT_W-1:0] tmr_ff;
  logic [CNT_W-1:0] nxt_tmr;
  logic [2:0]       idx_ff;
  logic [7:0]       rx_ff;
  logic [7:0]       last_byte_ff;

  wire tmr_zero  = (tmr_ff == '0);
  wire [CNT_W-1:0] tmr_dec = tmr_ff - CNT_W'(1);
  wire take_bit  = (fr_ff == FR_DATA) && tmr_zero;
  wire byte_done = (fr_ff == FR_STOP) && tmr_zero && mark;

  // Start checked mid-bit so data samples land mid-bit
  always_comb
  begin
    nxt_fr  = fr_ff;
    nxt_tmr = tmr_zero ? BIT_C : tmr_dec;
    unique case (fr_ff)
      FR_IDLE:
      begin
        nxt_tmr = HALF_C;
        if (carrier && !mark)
          nxt_fr = FR_START;
      end
      FR_START:
        if (tmr_zero)
          nxt_fr = mark ? FR_IDLE : FR_DATA;
      FR_DATA:
        if (tmr_zero && idx_ff == LAST_BIT)
          nxt_fr = FR_STOP;
      FR_STOP:
        if (tmr_zero)
          nxt_fr = FR_IDLE;
    endcase
    if (!carrier)
      nxt_fr = FR_IDLE;
  end

  always_ff @(posedge sys_clk_i)
  begin
    fr_ff  <= sys_rst_i ? FR_IDLE : nxt_fr;
    tmr_ff <= sys_rst_i ? '0 : nxt_tmr;
    if (sys_rst_i || fr_ff == FR_START)
      idx_ff <= '0;
    else if (take_bit)
      idx_ff <= idx_ff + 3'h1;
  end

  // Line order is LSB first, so shift in from the top
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      rx_ff <= '0;
    else if (take_bit)
      rx_ff <= {mark, rx_ff[7:1]};
    last_byte_ff <= sys_rst_i ? '0 : (byte_done ? rx_ff : last_byte_ff);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host serial port: raw stream in mode 0, clocked byte in mode 1

  logic [7:0] out_ff;
  logic [3:0] left_ff;
  logic       ready_n_ff;
  logic       sdata_ff;

  wire word_mode = active && byte_mode;
  wire load_word = word_mode && byte_done;
  wire shift_one = word_mode && !ready_n_ff && sclk_rise;
  wire last_out  = shift_one && (left_ff == 4'h1);

  // New word mid read-out overwrites the old: host was late
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i || !word_mode)
    begin
      out_ff     <= '0;
      left_ff    <= '0;
      ready_n_ff <= 1'b1;
    end
    else if (load_word)
    begin
      out_ff     <= rx_ff;
      left_ff    <= WORD_BITS;
      ready_n_ff <= 1'b0;
    end
    else if (shift_one)
    begin
      out_ff     <= {1'b0, out_ff[7:1]};
      left_ff    <= left_ff - 4'h1;
      ready_n_ff <= last_out;
    end
  end

  // Mode 0 passes the demodulated bit with no framing at all
  wire nxt_sdata = word_mode ? out_ff[0] : (!demod_on || mark);

  always_ff @(posedge sys_clk_i)
  begin
    sdata_ff <= sys_rst_i ? 1'b1 : nxt_sdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combined interrupt

  logic int_oe_ff;

  // Level OR: held until every source is inactive; all lag one cycle
  wire int_want = !call_n_ff || !ready_n_ff || tone_qual_ff;

  always_ff @(posedge sys_clk_i)
  begin
    int_oe_ff <= !sys_rst_i && int_want;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic              aw_have_ff;
  logic              w_have_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0]       w_data_ff;
  logic [3:0]        w_strb_ff;
  logic              awready_ff;
  logic              wready_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              arready_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  status_t           status;

  assign status = '{int_active:        int_oe_ff,
                    tone_qualified:    tone_qual_ff,
                    tone_early:        tone_early_ff,
                    call_arrival_n:    call_n_ff,
                    byte_ready_n:      ready_n_ff,
                    carrier_present_n: carrier_n_ff};

  wire aw_take   = s_axi_awvalid_i && awready_ff;
  wire w_take    = s_axi_wvalid_i && wready_ff;
  wire commit    = aw_have_ff && w_have_ff && !bvalid_ff;
  wire b_done    = bvalid_ff && s_axi_bready_i;
  wire nxt_bval  = commit || (bvalid_ff && !b_done);
  wire nxt_aw    = (aw_have_ff || aw_take) && !commit;
  wire nxt_w     = (w_have_ff || w_take) && !commit;
  wire wr_ctrl   = commit && aw_addr_ff == ADDR_CTRL && w_strb_ff[0];
  wire wr_known  = aw_addr_ff == ADDR_CTRL || aw_addr_ff == ADDR_STATUS
                   || aw_addr_ff == ADDR_BYTE;
  wire ar_take   = s_axi_arvalid_i && arready_ff;
  wire r_done    = rvalid_ff && s_axi_rready_i;
  wire nxt_rval  = ar_take || (rvalid_ff && !r_done);
  wire rd_ctrl   = s_axi_araddr_i == ADDR_CTRL;
  wire rd_stat   = s_axi_araddr_i == ADDR_STATUS;
  wire rd_byte   = s_axi_araddr_i == ADDR_BYTE;
  wire [31:0] rd_word = rd_ctrl ? {29'h0, ctrl_ff}
                      : rd_stat ? {26'h0, status}
                      : rd_byte ? {24'h0, last_byte_ff} : 32'h0;

  // AW and W land in either order; commit once both held
  always_ff @(posedge sys_clk_i)
  begin
    aw_have_ff <= !sys_rst_i && nxt_aw;
    w_have_ff  <= !sys_rst_i && nxt_w;
    awready_ff <= !sys_rst_i && !nxt_aw && !nxt_bval;
    wready_ff  <= !sys_rst_i && !nxt_w && !nxt_bval;
    bvalid_ff  <= !sys_rst_i && nxt_bval;
    aw_addr_ff <= aw_take ? s_axi_awaddr_i : aw_addr_ff;
    w_data_ff  <= w_take ? s_axi_wdata_i : w_data_ff;
    w_strb_ff  <= w_take ? s_axi_wstrb_i : w_strb_ff;
    if (commit)
      bresp_ff <= wr_known ? RESP_OKAY : RESP_SLVERR;
  end

  // Only control bits are writable; other writes are ignored
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      ctrl_ff <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl_ff <= w_data_ff[2:0];
  end

  always_ff @(posedge sys_clk_i)
  begin
    arready_ff <= !sys_rst_i && !nxt_rval;
    rvalid_ff  <= !sys_rst_i && nxt_rval;
    if (ar_take)
    begin
      rdata_ff <= rd_word;
      rresp_ff <= (rd_ctrl || rd_stat || rd_byte) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output wiring

  assign s_axi_awready_o      = awready_ff;
  assign s_axi_wready_o       = wready_ff;
  assign s_axi_bvalid_o       = bvalid_ff;
  assign s_axi_bresp_o        = bresp_ff;
  assign s_axi_arready_o      = arready_ff;
  assign s_axi_rvalid_o       = rvalid_ff;
  assign s_axi_rdata_o        = rdata_ff;
  assign s_axi_rresp_o        = rresp_ff;
  assign hold_rc_node_o       = od_low_ff;
  assign hold_rc_node_oe_o    = rc_oe_ff;
  assign call_arrival_out_o   = call_n_ff;
  assign tone_early_out_o     = tone_early_ff;
  assign tone_qualified_out_o = tone_qual_ff;
  assign serial_data_o        = sdata_ff;
  assign byte_ready_n_o       = ready_n_ff;
  assign carrier_present_n_o  = carrier_n_ff;
  assign int_n_o              = od_low_ff;
  assign int_n_oe_o           = int_oe_ff;

endmodule

// >>> cid_host_reader.sv
`timescale 1ns/10ps
module cid_host_reader
(
  // From the decoder
  input  wire logic byte_ready_n_i,
  input  wire logic serial_data_i,
  // Host side
  output logic       shift_clock_o,
  output logic [7:0] byte_o,
  output logic [3:0] count_o
);
  // Clock idles low; phase unrelated to sys clock
  initial
  begin
    shift_clock_o = 1'b0;
    byte_o = 8'h00;
    count_o = 4'h0;
    #7;
    forever
    begin
      wait (byte_ready_n_i === 1'b0);
      // Bit 0 already shown; sample before each rise
      for (int i = 0; i < 8; i++)
      begin
        #100;
        byte_o[i] = serial_data_i;
        shift_clock_o = 1'b1;
        #100;
        shift_clock_o = 1'b0;
      end
      count_o = count_o + 4'h1;
      wait (byte_ready_n_i !== 1'b0);
    end
  end
endmodule

// >>> caller_id_serial_status_interface_assertions.sv
`timescale 1ns/10ps
module cid_checker
  import cid_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  // Register writes
  input wire logic [3:0]  s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0]  s_axi_wstrb_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  // Pins
  input wire logic        ring_sense_in_i,
  input wire logic        hold_rc_node_i,
  input wire logic        hold_rc_node_o,
  input wire logic        hold_rc_node_oe_o,
  input wire logic        call_arrival_out_o,
  input wire logic        tone_pair_det_i,
  input wire logic        guard_time_node_i,
  input wire logic        tone_early_out_o,
  input wire logic        tone_qualified_out_o,
  input wire logic        byte_ready_n_o,
  input wire logic        carrier_present_n_o,
  input wire logic        int_n_o,
  input wire logic        int_n_oe_o
);
  logic [3:0] wa_ff;
  logic [3:0] wd_ff;
  logic       bv_ff;
  ctrl_t      ctrl_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Ctrl mirror lags one cycle; repeats absorb it
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_ff <= CTRL_RESET;
      bv_ff <= 1'b0;
    end
    else
    begin
      bv_ff <= s_axi_bvalid_o;
      if (s_axi_awvalid_i && s_axi_awready_o)
        wa_ff <= s_axi_awaddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o)
        wd_ff <= {s_axi_wstrb_i[0], s_axi_wdata_i[2:0]};
      if (s_axi_bvalid_o && !bv_ff && s_axi_bresp_o == RESP_OKAY
          && wa_ff == ADDR_CTRL && wd_ff[3])
        ctrl_ff <= ctrl_t'(wd_ff[2:0]);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  chk_call_active: assert property (
    (ring_sense_in_i || !hold_rc_node_i) [*5] |-> !call_arrival_out_o)
    else $error("call not low");
  chk_call_idle: assert property (
    (!ring_sense_in_i && hold_rc_node_i) [*5] |-> call_arrival_out_o)
    else $error("call not high");
  chk_node_discharge: assert property (
    ring_sense_in_i [*5] |-> hold_rc_node_oe_o && !hold_rc_node_o)
    else $error("no discharge");
  chk_open_drain: assert property (
    !int_n_o && !hold_rc_node_o)
    else $error("od high");
  chk_int_source: assert property (
    (!call_arrival_out_o || !byte_ready_n_o || tone_qualified_out_o)
    |=> int_n_oe_o)
    else $error("int not set");
  chk_int_release: assert property (
    (call_arrival_out_o && byte_ready_n_o && !tone_qualified_out_o)
    |=> !int_n_oe_o)
    else $error("int held");
  chk_tone_early: assert property (
    (!ctrl_ff.power_down && tone_pair_det_i) [*5] |-> tone_early_out_o)
    else $error("no early");
  chk_tone_qual: assert property (
    (!ctrl_ff.power_down && guard_time_node_i) [*5]
    |-> tone_qualified_out_o)
    else $error("no qual");
  chk_tone_rearm: assert property (
    (!guard_time_node_i) [*5] |-> !tone_qualified_out_o)
    else $error("qual no guard");
  chk_power_quiet: assert property (
    ctrl_ff.power_down [*5]
    |-> !tone_early_out_o && !tone_qualified_out_o && carrier_present_n_o)
    else $error("pd active");
  chk_raw_ready: assert property (
    (!ctrl_ff.mode) [*8] |-> byte_ready_n_o)
    else $error("raw ready");
  // Main scenarios
  cover property ($fell(byte_ready_n_o));
  cover property ($fell(carrier_present_n_o));
  cover property ($rose(tone_qualified_out_o));
  cover property ($fell(call_arrival_out_o));
endmodule

bind caller_id_serial_status_interface cid_checker chk (
  .sys_clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .ring_sense_in_i,
  .hold_rc_node_i, .hold_rc_node_o, .hold_rc_node_oe_o,
  .call_arrival_out_o, .tone_pair_det_i, .guard_time_node_i,
  .tone_early_out_o, .tone_qualified_out_o, .byte_ready_n_o,
  .carrier_present_n_o, .int_n_o, .int_n_oe_o
);

// >>> caller_id_serial_status_interface_bench.sv
`timescale 1ns/10ps
module caller_id_serial_status_interface_bench
  import cid_pkg::*;
;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  s_axi_awaddr_i = 4'h0;
  logic [3:0]  s_axi_araddr_i = 4'h0;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic        s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic        s_axi_rready_i = 1'b0, ring_sense_in_i = 1'b0;
  logic        rc_charged = 1'b1, tone_pair_det_i = 1'b0;
  logic        guard_time_node_i = 1'b0, fsk_line_sq_i = 1'b0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_arready_o, s_axi_rvalid_o, hold_rc_node_o;
  logic        hold_rc_node_oe_o, call_arrival_out_o, serial_data_o;
  logic        tone_early_out_o, tone_qualified_out_o, int_n_o;
  logic        byte_ready_n_o, carrier_present_n_o, int_n_oe_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [7:0]  host_byte;
  logic [3:0]  host_count;
  wire         hold_rc_node_i, int_wire, shift_clock_in_i;
  int          failures = 0, check_count = 0, cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  // RC node low while discharged; pull-up on int
  assign hold_rc_node_i = hold_rc_node_oe_o ? hold_rc_node_o : rc_charged;
  assign int_wire = int_n_oe_o ? int_n_o : 1'b1;
  always #12.5 sys_clk_i = ~sys_clk_i;
  caller_id_serial_status_interface #(
    .BIT_CYC(64), .HALF_MIN(8), .HALF_MAX(20), .HALF_SPLIT(12)
  ) dut (
    .sys_clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .ring_sense_in_i,
    .hold_rc_node_i, .hold_rc_node_o, .hold_rc_node_oe_o,
    .call_arrival_out_o, .tone_pair_det_i, .guard_time_node_i,
    .tone_early_out_o, .tone_qualified_out_o, .fsk_line_sq_i,
    .shift_clock_in_i, .serial_data_o, .byte_ready_n_o,
    .carrier_present_n_o, .int_n_o, .int_n_oe_o
  );
  cid_host_reader host (
    .byte_ready_n_i(byte_ready_n_o), .serial_data_i(serial_data_o),
    .shift_clock_o(shift_clock_in_i), .byte_o(host_byte),
    .count_o(host_count)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t: %s got %b exp %b", $time, m, got, exp);
    end
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
                            input string m);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // AW and W offered together, each dropped once taken
  task automatic wr_chk(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    forever
    begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o)
        s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o)
        s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o)
        break;
    end
    s_axi_bready_i <= 1'b0;
    check_word({30'h0, s_axi_bresp_o}, {30'h0, r}, "bresp");
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    forever
    begin
      @(posedge sys_clk_i);
      if (s_axi_arready_o)
        s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o)
        break;
    end
    s_axi_rready_i <= 1'b0;
    check_word(s_axi_rdata_o, d, "rdata");
    check_word({30'h0, s_axi_rresp_o}, {30'h0, r}, "rresp");
  endtask
  // 64-cycle bits: mark halves of 16, space halves of 10 or 11
  task automatic fsk_bit(input logic v);
    for (int i = 0; i < (v ? 4 : 6); i++)
    begin
      repeat (v ? 16 : ((i == 0 || i == 5) ? 10 : 11)) @(posedge sys_clk_i);
      fsk_line_sq_i <= ~fsk_line_sq_i;
    end
  endtask
  task automatic fsk_byte(input logic [7:0] b);
    repeat (8) fsk_bit(1'b1);
    fsk_bit(1'b0);
    for (int i = 0; i < 8; i++)
      fsk_bit(b[i]);
    repeat (2) fsk_bit(1'b1);
  endtask
  task automatic pause();
    repeat (8) @(posedge sys_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard; run needs about 4000 cycles
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  initial
  begin
    logic [7:0] b;
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    // Map, reset values, read-only, unmapped
    rd_chk(ADDR_CTRL, 32'h0, RESP_OKAY);
    rd_chk(ADDR_STATUS, 32'h7, RESP_OKAY);
    rd_chk(4'hC, 32'h0, RESP_SLVERR);
    wr_chk(4'hC, 32'h1, RESP_SLVERR);
    wr_chk(ADDR_STATUS, 32'h0, RESP_OKAY);
    rd_chk(ADDR_STATUS, 32'h7, RESP_OKAY);
    wr_chk(ADDR_CTRL, 32'hFFFFFFF9, RESP_OKAY);
    rd_chk(ADDR_CTRL, 32'h1, RESP_OKAY);
    // Trigger lives in power down, tones do not
    wr_chk(ADDR_CTRL, 32'h4, RESP_OKAY);
    ring_sense_in_i <= 1'b1;
    rc_charged <= 1'b0;
    tone_pair_det_i <= 1'b1;
    guard_time_node_i <= 1'b1;
    pause();
    check_bit(tone_early_out_o, 1'b0, "pd early");
    check_bit(tone_qualified_out_o, 1'b0, "pd qual");
    check_bit(call_arrival_out_o, 1'b0, "ring");
    check_bit(hold_rc_node_i, 1'b0, "node");
    check_bit(int_wire, 1'b0, "int ring");
    ring_sense_in_i <= 1'b0;
    pause();
    check_bit(call_arrival_out_o, 1'b0, "rc hold");
    rc_charged <= 1'b1;
    pause();
    check_bit(call_arrival_out_o, 1'b1, "idle");
    check_bit(int_wire, 1'b1, "int off");
    wr_chk(ADDR_CTRL, 32'h0, RESP_OKAY);
    pause();
    check_bit(tone_early_out_o, 1'b1, "early");
    check_bit(tone_qualified_out_o, 1'b1, "qual");
    check_bit(int_wire, 1'b0, "int tone");
    rd_chk(ADDR_STATUS, 32'h3F, RESP_OKAY);
    guard_time_node_i <= 1'b0;
    pause();
    check_bit(tone_qualified_out_o, 1'b0, "rearm");
    check_bit(tone_early_out_o, 1'b1, "early");
    check_bit(int_wire, 1'b1, "int off");
    tone_pair_det_i <= 1'b0;
    // Raw mode, demod off then on
    for (int en = 0; en < 2; en++)
    begin
      wr_chk(ADDR_CTRL, {30'h0, en[0], 1'b0}, RESP_OKAY);
      repeat (8) fsk_bit(1'b1);
      check_bit(carrier_present_n_o, !en[0], "carrier");
      fsk_bit(1'b0);
      repeat (6) @(posedge sys_clk_i);
      check_bit(serial_data_o, !en[0], "space");
      fsk_bit(1'b1);
      repeat (6) @(posedge sys_clk_i);
      check_bit(serial_data_o, 1'b1, "mark");
      repeat (30) @(posedge sys_clk_i);
      check_bit(carrier_present_n_o, 1'b1, "no carrier");
      check_bit(byte_ready_n_o, 1'b1, "raw ready");
    end
    // Byte mode: host clocks each word out
    wr_chk(ADDR_CTRL, 32'h3, RESP_OKAY);
    for (int k = 0; k < 2; k++)
    begin
      b = k ? 8'h3C : 8'hA5;
      fsk_byte(b);
      for (int i = 0; i < 4000 && host_count != 4'(k + 1); i++)
        @(posedge sys_clk_i);
      check_word({24'h0, host_byte}, {24'h0, b}, "byte");
      check_bit(byte_ready_n_o, 1'b1, "ready off");
      check_bit(int_wire, 1'b1, "int off");
      rd_chk(ADDR_BYTE, {24'h0, b}, RESP_OKAY);
    end
    tally_and_finish();
  end
endmodule
